/* File: l1i_pkg.sv */
// Purpose: Shared constants and carriers for the level-1 interrupt mask and route stage.
// Assumes: Registers are 16 bits wide; the bus decodes each register at its full byte address.
// Notes:   The event registers let software see when a processor request line goes active.
package l1i_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned EVT_W  = 4;

  // Register byte addresses; the bus matches them in full, with no scaling.
  localparam logic [31:0] IDX_STATUS_ONE = 32'h0a000080;
  localparam logic [31:0] IDX_MASK_ONE   = 32'h0a00008c;
  localparam logic [31:0] IDX_ROUTE      = 32'h0a000098;
  localparam logic [31:0] IDX_SOFT       = 32'h0a00009a;
  localparam logic [31:0] IDX_STATUS_TWO = 32'h0a000200;
  localparam logic [31:0] IDX_EVT_STATUS = 32'h0a000300;
  localparam logic [31:0] IDX_EVT_MASK   = 32'h0a000302;

  localparam logic [31:0] ADR_STATUS_ONE = IDX_STATUS_ONE;
  localparam logic [31:0] ADR_MASK_ONE   = IDX_MASK_ONE;
  localparam logic [31:0] ADR_ROUTE      = IDX_ROUTE;
  localparam logic [31:0] ADR_SOFT       = IDX_SOFT;
  localparam logic [31:0] ADR_STATUS_TWO = IDX_STATUS_TWO;
  localparam logic [31:0] ADR_EVT_STATUS = IDX_EVT_STATUS;
  localparam logic [31:0] ADR_EVT_MASK   = IDX_EVT_MASK;

  // Bit positions shared by the level-1 status one and mask one layouts.
  localparam int unsigned BIT_TOUCH_SUSPEND = 13;
  localparam int unsigned BIT_SOFTWARE      = 11;
  localparam int unsigned BIT_SERIAL        = 9;
  localparam int unsigned BIT_GPIO          = 8;
  localparam int unsigned BIT_KEYBOARD      = 7;
  localparam int unsigned BIT_AUDIO         = 6;
  localparam int unsigned BIT_TOUCH         = 5;
  localparam int unsigned BIT_ELAPSED       = 3;
  localparam int unsigned BIT_LONG_TIMER1   = 2;
  localparam int unsigned BIT_POWER         = 1;
  localparam int unsigned BIT_BATTERY       = 0;

  // Bit positions of level-1 status two.
  localparam int unsigned BIT_DISPLAY     = 6;
  localparam int unsigned BIT_DMA         = 5;
  localparam int unsigned BIT_CLK_SERIAL  = 3;
  localparam int unsigned BIT_CARD_SLOT   = 2;
  localparam int unsigned BIT_LED         = 1;
  localparam int unsigned BIT_LONG_TIMER2 = 0;

  localparam int unsigned BIT_ROUTE_SELECT = 0;
  localparam int unsigned BIT_SOFT_REQUEST = 0;

  // Event bit positions.
  localparam int unsigned EVT_NMI  = 0;
  localparam int unsigned EVT_CPU_GENERAL_IRQ_ZERO = 1;
  localparam int unsigned EVT_INT1 = 2;
  localparam int unsigned EVT_INT2 = 3;

  // Implemented bit sets.
  localparam logic [15:0] MASK_ONE_BITS  = 16'h2bef;
  localparam logic [15:0] CPU_GENERAL_IRQ_ZERO_ONE_BITS  = 16'h2bea;
  localparam logic [15:0] STATUS_TWO_BITS = 16'h006f;
  localparam logic [15:0] CPU_GENERAL_IRQ_ZERO_TWO_BITS  = 16'h006e;
  localparam logic [15:0] ROUTE_BITS     = 16'h0001;

  // Values after reset.
  localparam logic [15:0] MASK_ONE_RESET  = 16'h0000;
  localparam logic [15:0] ROUTE_RESET     = 16'h0000;
  localparam logic        SOFT_RESET      = 1'b0;
  localparam logic [3:0]  EVT_RESET       = 4'h0;
  localparam logic [3:0]  EVT_MASK_RESET  = 4'h0;
  localparam logic [15:0] READ_RESET      = 16'h0000;
  localparam logic        CPU_LINE_IDLE   = 1'b1;
  localparam logic        IRQ_RESET       = 1'b0;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } l1i_bus_t;

  typedef struct packed {
    logic touch_suspend;
    logic serial;
    logic gpio;
    logic keyboard;
    logic audio;
    logic touch;
    logic elapsed_timer;
    logic long_timer1;
    logic power_switch;
    logic battery_low;
  } l1i_src_one_t;

  typedef struct packed {
    logic display;
    logic dma;
    logic clocked_serial;
    logic card_slot;
    logic led;
    logic long_timer2;
  } l1i_src_two_t;

  typedef struct packed {
    logic nmi_n;
    logic general_zero_n;
    logic general_one_n;
    logic general_two_n;
    logic general_three_n;
  } l1i_cpu_t;

endpackage : l1i_pkg

/* File: l1i_level1_irq.sv */
// Purpose: Level-1 interrupt stage: masks peripheral requests, routes battery low, drives CPU lines.
// Assumes: Request inputs come from logic on ref_clk; both resets are asynchronous, active high.
// Notes:   CPU request lines are active low and registered, so they follow a cause by one cycle.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module l1i_level1_irq (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clock_domain_reset,
  input  wire l1i_pkg::l1i_bus_t bus,
  output logic [15:0]           read_data,
  input  wire l1i_pkg::l1i_src_one_t src_one,
  input  wire l1i_pkg::l1i_src_two_t src_two,
  input  wire logic [15:0]      status_two_enable,
  output l1i_pkg::l1i_cpu_t     cpu,
  output logic                  irq
);

  logic        rst_any;
  logic [15:0] status_one;
  logic [15:0] status_two;
  logic [15:0] mask_one;
  logic [15:0] route;
  logic        software_request;
  logic [15:0] enabled_one;
  logic [15:0] enabled_two;
  logic        battery_enabled;
  logic        next_nmi_req;
  logic        next_cpu_general_irq_zero_req;
  logic        next_int1_req;
  logic        next_int2_req;
  logic [3:0]  line_req;
  logic [3:0]  line_active;
  logic [3:0]  evt_set;
  logic [3:0]  evt_status;
  logic [3:0]  evt_mask;
  logic        wr_mask_one;
  logic        wr_route;
  logic        wr_soft;
  logic        wr_evt_status;
  logic        wr_evt_mask;

  // either reset
  // Both resets clear the same state, so they are simply merged.
  assign rst_any = rst | clock_domain_reset;

  // decoded writes
  // Only the writable registers have a write decode; status one and status two writes fall away.
  assign wr_mask_one   = bus.wr && (bus.addr == l1i_pkg::ADR_MASK_ONE);
  assign wr_route      = bus.wr && (bus.addr == l1i_pkg::ADR_ROUTE);
  assign wr_soft       = bus.wr && (bus.addr == l1i_pkg::ADR_SOFT);
  assign wr_evt_status = bus.wr && (bus.addr == l1i_pkg::ADR_EVT_STATUS);
  assign wr_evt_mask   = bus.wr && (bus.addr == l1i_pkg::ADR_EVT_MASK);

  always_comb begin
    status_one = 16'h0000;
    status_one[l1i_pkg::BIT_TOUCH_SUSPEND] = src_one.touch_suspend;
    status_one[l1i_pkg::BIT_SOFTWARE]      = software_request;
    status_one[l1i_pkg::BIT_SERIAL]        = src_one.serial;
    status_one[l1i_pkg::BIT_GPIO]          = src_one.gpio;
    status_one[l1i_pkg::BIT_KEYBOARD]      = src_one.keyboard;
    status_one[l1i_pkg::BIT_AUDIO]         = src_one.audio;
    status_one[l1i_pkg::BIT_TOUCH]         = src_one.touch;
    status_one[l1i_pkg::BIT_ELAPSED]       = src_one.elapsed_timer;
    status_one[l1i_pkg::BIT_LONG_TIMER1]   = src_one.long_timer1;
    status_one[l1i_pkg::BIT_POWER]         = src_one.power_switch;
    status_one[l1i_pkg::BIT_BATTERY]       = src_one.battery_low;
  end

  always_comb begin
    status_two = 16'h0000;
    status_two[l1i_pkg::BIT_DISPLAY]     = src_two.display;
    status_two[l1i_pkg::BIT_DMA]         = src_two.dma;
    status_two[l1i_pkg::BIT_CLK_SERIAL]  = src_two.clocked_serial;
    status_two[l1i_pkg::BIT_CARD_SLOT]   = src_two.card_slot;
    status_two[l1i_pkg::BIT_LED]         = src_two.led;
    status_two[l1i_pkg::BIT_LONG_TIMER2] = src_two.long_timer2;
  end

  // through share one store; the writable set keeps reserved bits at zero.
  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      mask_one <= l1i_pkg::MASK_ONE_RESET;
    end else if (wr_mask_one) begin
      mask_one <= bus.wdata & l1i_pkg::MASK_ONE_BITS;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      route <= l1i_pkg::ROUTE_RESET;
    end else if (wr_route) begin
      route <= bus.wdata & l1i_pkg::ROUTE_BITS;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      software_request <= l1i_pkg::SOFT_RESET;
    end else if (wr_soft) begin
      software_request <= bus.wdata[l1i_pkg::BIT_SOFT_REQUEST];
    end
  end

  // status AND mask
  // Status two is gated by the level-2 style enable vector supplied from outside.
  assign enabled_one     = status_one & mask_one;
  assign enabled_two     = status_two & status_two_enable & l1i_pkg::STATUS_TWO_BITS;
  assign battery_enabled = enabled_one[l1i_pkg::BIT_BATTERY];

  // battery routing
  // The nmi path cannot be masked later by the core, hence the mask bit here.
  assign next_nmi_req  = battery_enabled & ~route[l1i_pkg::BIT_ROUTE_SELECT];
  assign next_cpu_general_irq_zero_req = (|(enabled_one & l1i_pkg::CPU_GENERAL_IRQ_ZERO_ONE_BITS))
                       | (battery_enabled & route[l1i_pkg::BIT_ROUTE_SELECT])
                       | (|(enabled_two & l1i_pkg::CPU_GENERAL_IRQ_ZERO_TWO_BITS));
  assign next_int1_req = enabled_one[l1i_pkg::BIT_LONG_TIMER1];
  assign next_int2_req = enabled_two[l1i_pkg::BIT_LONG_TIMER2];

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      cpu.nmi_n           <= l1i_pkg::CPU_LINE_IDLE;
      cpu.general_zero_n  <= l1i_pkg::CPU_LINE_IDLE;
      cpu.general_one_n   <= l1i_pkg::CPU_LINE_IDLE;
      cpu.general_two_n   <= l1i_pkg::CPU_LINE_IDLE;
      cpu.general_three_n <= l1i_pkg::CPU_LINE_IDLE;
    end else begin
      cpu.nmi_n           <= ~next_nmi_req;
      cpu.general_zero_n  <= ~next_cpu_general_irq_zero_req;
      cpu.general_one_n   <= ~next_int1_req;
      cpu.general_two_n   <= ~next_int2_req;
      cpu.general_three_n <= l1i_pkg::CPU_LINE_IDLE;
    end
  end

  // An event is a line going active; a line that stays active raises no new event.
  assign line_req[l1i_pkg::EVT_NMI]     = next_nmi_req;
  assign line_req[l1i_pkg::EVT_CPU_GENERAL_IRQ_ZERO]    = next_cpu_general_irq_zero_req;
  assign line_req[l1i_pkg::EVT_INT1]    = next_int1_req;
  assign line_req[l1i_pkg::EVT_INT2]    = next_int2_req;
  assign line_active[l1i_pkg::EVT_NMI]  = ~cpu.nmi_n;
  assign line_active[l1i_pkg::EVT_CPU_GENERAL_IRQ_ZERO] = ~cpu.general_zero_n;
  assign line_active[l1i_pkg::EVT_INT1] = ~cpu.general_one_n;
  assign line_active[l1i_pkg::EVT_INT2] = ~cpu.general_two_n;
  assign evt_set = line_req & ~line_active;

  // A new event in the clearing cycle wins, so no edge is lost to a late clear.
  for (genvar i = 0; i < l1i_pkg::EVT_W; i++) begin : g_evt
    always_ff @(posedge ref_clk or posedge rst_any) begin
      if (rst_any) begin
        evt_status[i] <= l1i_pkg::EVT_RESET[i];
      end else if (evt_set[i]) begin
        evt_status[i] <= 1'b1;
      end else if (wr_evt_status && bus.wdata[i]) begin
        evt_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      evt_mask <= l1i_pkg::EVT_MASK_RESET;
    end else if (wr_evt_mask) begin
      evt_mask <= bus.wdata[l1i_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      irq <= l1i_pkg::IRQ_RESET;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge ref_clk or posedge rst_any) begin
    if (rst_any) begin
      read_data <= l1i_pkg::READ_RESET;
    end else if (bus.rd) begin
      case (bus.addr)
        l1i_pkg::ADR_STATUS_ONE: begin
          read_data <= status_one & l1i_pkg::MASK_ONE_BITS;
        end
        l1i_pkg::ADR_MASK_ONE: begin
          read_data <= mask_one;
        end
        l1i_pkg::ADR_ROUTE: begin
          read_data <= route;
        end
        l1i_pkg::ADR_SOFT: begin
          read_data <= l1i_pkg::READ_RESET;
        end
        l1i_pkg::ADR_STATUS_TWO: begin
          read_data <= status_two;
        end
        l1i_pkg::ADR_EVT_STATUS: begin
          read_data <= {12'h000, evt_status};
        end
        l1i_pkg::ADR_EVT_MASK: begin
          read_data <= {12'h000, evt_mask};
        end
        default: begin
          read_data <= l1i_pkg::READ_RESET;
        end
      endcase
    end else begin
      read_data <= l1i_pkg::READ_RESET;
    end
  end

endmodule : l1i_level1_irq

`default_nettype wire

/* File: l1i_level1_irq_properties.sv */
// Purpose: Port-level assertions for the level-1 interrupt mask and route stage.
// Assumes: Shadow copies of mask, route and software bits follow bus writes.
// Notes:   CPU lines are judged one cycle after their cause, as the stage registers them.
`timescale 1ns/1ps
`default_nettype none
module l1i_level1_irq_properties (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire logic                  clock_domain_reset,
  input wire l1i_pkg::l1i_bus_t     bus,
  input wire logic [15:0]           read_data,
  input wire l1i_pkg::l1i_src_one_t src_one,
  input wire l1i_pkg::l1i_src_two_t src_two,
  input wire logic [15:0]           status_two_enable,
  input wire l1i_pkg::l1i_cpu_t     cpu,
  input wire logic                  irq
);
  logic [15:0] sh_mask, stat1, stat2;
  logic        sh_route, sh_soft, want0;

  always_ff @(posedge ref_clk or posedge rst or posedge clock_domain_reset) begin
    if (rst || clock_domain_reset) begin
      sh_mask  <= 16'h0;
      sh_route <= 1'b0;
      sh_soft  <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == l1i_pkg::ADR_MASK_ONE) sh_mask <= bus.wdata & 16'h2bef;
      if (bus.addr == l1i_pkg::ADR_ROUTE) sh_route <= bus.wdata[0];
      if (bus.addr == l1i_pkg::ADR_SOFT) sh_soft <= bus.wdata[0];
    end
  end

  // Status layouts rebuilt from the sources, so a swapped bit shows up at once.
  always_comb begin
    stat1 = {2'b0, src_one[9], 1'b0, sh_soft, 1'b0, src_one[8:4], 1'b0, src_one[3:0]};
    stat2 = {9'h0, src_two[5:4], 1'b0, src_two[3:0]};
    want0 = |(stat1 & sh_mask & 16'h2bea) | (src_one.battery_low & sh_mask[0] & sh_route)
            | |(stat2 & status_two_enable & 16'h006e);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || clock_domain_reset);

  property p_three_idle;
    cpu.general_three_n == 1'b1;
  endproperty
  a_three_idle: assert property (p_three_idle) else $error("input three active");
  property p_nmi;
    1'b1 |=> cpu.nmi_n == !$past(src_one.battery_low & sh_mask[0] & !sh_route);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi line wrong");
  property p_cpu_general_irq_zero;
    1'b1 |=> cpu.general_zero_n == !$past(want0);
  endproperty
  a_cpu_general_irq_zero: assert property (p_cpu_general_irq_zero) else $error("general zero line wrong");
  property p_int1;
    1'b1 |=> cpu.general_one_n == !$past(src_one.long_timer1 & sh_mask[2]);
  endproperty
  a_int1: assert property (p_int1) else $error("general one line wrong");
  property p_int2;
    1'b1 |=> cpu.general_two_n == !$past(src_two.long_timer2 & status_two_enable[0]);
  endproperty
  a_int2: assert property (p_int2) else $error("general two line wrong");
  property p_mask_read;
    bus.rd && bus.addr == l1i_pkg::ADR_MASK_ONE |=> read_data == $past(sh_mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");
  property p_route_read;
    bus.rd && bus.addr == l1i_pkg::ADR_ROUTE |=> read_data == {15'h0, $past(sh_route)};
  endproperty
  a_route_read: assert property (p_route_read) else $error("route read wrong");
  property p_soft_read;
    bus.rd && bus.addr == l1i_pkg::ADR_SOFT |=> read_data == 16'h0;
  endproperty
  a_soft_read: assert property (p_soft_read) else $error("software read not zero");
  property p_two_read;
    bus.rd && bus.addr == l1i_pkg::ADR_STATUS_TWO |=> read_data == $past(stat2);
  endproperty
  a_two_read: assert property (p_two_read) else $error("status two read wrong");
endmodule : l1i_level1_irq_properties

bind l1i_level1_irq l1i_level1_irq_properties i_l1i_level1_irq_properties (
  .ref_clk(ref_clk), .rst(rst), .clock_domain_reset(clock_domain_reset), .bus(bus),
  .read_data(read_data), .src_one(src_one), .src_two(src_two),
  .status_two_enable(status_two_enable), .cpu(cpu), .irq(irq));
`default_nettype wire

/* File: l1i_src_model.sv */
// Purpose: Peripheral request sources feeding the level-1 stage.
// Assumes: Requests are given in the status register bit layouts.
// Notes:   Registered, so requests change just after an edge like real unit logic.
`timescale 1ns/1ps
`default_nettype none
module l1i_src_model (
  input  wire logic                 ref_clk,
  input  wire logic [15:0]          want_one,
  input  wire logic [15:0]          want_two,
  output var l1i_pkg::l1i_src_one_t src_one,
  output var l1i_pkg::l1i_src_two_t src_two
);
  always_ff @(posedge ref_clk) begin
    src_one <= {want_one[13], want_one[9:5], want_one[3:0]};
    src_two <= {want_two[6:5], want_two[3:0]};
  end
endmodule : l1i_src_model
`default_nettype wire

/* File: l1i_level1_irq_test.sv */
// Purpose: Self-checking bench for the level-1 interrupt mask and route stage.
// Assumes: Sources come from the registered source model, two cycles to a CPU line.
// Notes:   Table rows cover masking and routing; odd cases follow by hand.
`timescale 1ns/1ps
`default_nettype none
module l1i_level1_irq_test;
  typedef struct packed {
    logic [15:0] m;
    logic        r;
    logic [15:0] s1, s2, e2;
    logic [4:0]  c;
  } l1i_row_t;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  clock_domain_reset = 1'b0;
  l1i_pkg::l1i_bus_t     bus = '0;
  logic [15:0]           want_one = 16'h0, want_two = 16'h0, status_two_enable = 16'h0;
  logic [15:0]           read_data;
  l1i_pkg::l1i_src_one_t src_one;
  l1i_pkg::l1i_src_two_t src_two;
  l1i_pkg::l1i_cpu_t     cpu;
  logic                  irq;
  int                    n_mismatch = 0, total_checks = 0;
  l1i_row_t rows [14] = '{
    '{16'h2000, 1'b0, 16'h2000, 16'h0, 16'h0, 5'h17},
    '{16'h0200, 1'b0, 16'h0200, 16'h0, 16'h0, 5'h17},
    '{16'h0100, 1'b0, 16'h0100, 16'h0, 16'h0, 5'h17},
    '{16'h00e0, 1'b0, 16'h0080, 16'h0, 16'h0, 5'h17},
    '{16'h0008, 1'b0, 16'h0008, 16'h0, 16'h0, 5'h17},
    '{16'h0004, 1'b0, 16'h0004, 16'h0, 16'h0, 5'h1b},
    '{16'h0002, 1'b0, 16'h0002, 16'h0, 16'h0, 5'h17},
    '{16'h0001, 1'b0, 16'h0001, 16'h0, 16'h0, 5'h0f},
    '{16'h0001, 1'b1, 16'h0001, 16'h0, 16'h0, 5'h17},
    '{16'h0000, 1'b1, 16'h2bef, 16'h0, 16'h0, 5'h1f},
    '{16'hffdf, 1'b0, 16'h0020, 16'h0, 16'h0, 5'h1f},
    '{16'h0000, 1'b0, 16'h0, 16'h0001, 16'h0001, 5'h1d},
    '{16'h0000, 1'b0, 16'h0, 16'h006e, 16'h006e, 5'h17},
    '{16'h0000, 1'b0, 16'h0, 16'h006f, 16'h0000, 5'h1f}};

  always #5 ref_clk = ~ref_clk;

  l1i_level1_irq i_l1i_level1_irq (.ref_clk(ref_clk), .rst(rst),
    .clock_domain_reset(clock_domain_reset), .bus(bus), .read_data(read_data),
    .src_one(src_one), .src_two(src_two), .status_two_enable(status_two_enable),
    .cpu(cpu), .irq(irq));
  l1i_src_model i_l1i_src_model (.ref_clk(ref_clk), .want_one(want_one),
    .want_two(want_two), .src_one(src_one), .src_two(src_two));

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [31:0] a, logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(logic [31:0] a, logic [15:0] e, string what);
    @(posedge ref_clk);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 chk(what, e, read_data);
  endtask : rd
  // Source model and output register each add one cycle.
  task automatic lines(logic [4:0] e, logic q);
    repeat (4) @(posedge ref_clk);
    #1 chk("cpu lines", {11'h0, e}, {11'h0, cpu});
    chk("irq", {15'h0, q}, {15'h0, irq});
  endtask : lines
  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(l1i_pkg::ADR_MASK_ONE, 16'h0, "mask one");
    rd(l1i_pkg::ADR_ROUTE, 16'h0, "route");
    lines(5'h1f, 1'b0);
    foreach (rows[i]) begin
      wr(l1i_pkg::ADR_MASK_ONE, rows[i].m);
      wr(l1i_pkg::ADR_ROUTE, {15'h0, rows[i].r});
      want_one <= rows[i].s1;
      want_two <= rows[i].s2;
      status_two_enable <= rows[i].e2;
      lines(rows[i].c, 1'b0);
      rd(l1i_pkg::ADR_MASK_ONE, rows[i].m & 16'h2bef, "mask one");
    end
    rd(l1i_pkg::ADR_STATUS_TWO, 16'h006f, "status two");
    wr(l1i_pkg::ADR_STATUS_TWO, 16'hffff);
    want_two <= 16'h0;
    rd(l1i_pkg::ADR_STATUS_TWO, 16'h0, "status two");
    rd(l1i_pkg::ADR_MASK_ONE + 32'h4, 16'h0, "unmapped");
    wr(l1i_pkg::ADR_MASK_ONE, 16'h0800);
    wr(l1i_pkg::ADR_SOFT, 16'h0001);
    lines(5'h17, 1'b0);
    rd(l1i_pkg::ADR_SOFT, 16'h0, "software");
    rd(l1i_pkg::ADR_STATUS_ONE, 16'h0800, "status one");
    wr(l1i_pkg::ADR_SOFT, 16'h0000);
    lines(5'h1f, 1'b0);
    wr(l1i_pkg::ADR_ROUTE, 16'hffff);
    rd(l1i_pkg::ADR_ROUTE, 16'h0001, "route");
    wr(l1i_pkg::ADR_MASK_ONE, 16'h0000);
    want_one <= 16'h0001;
    lines(5'h1f, 1'b0);
    // Earlier rows left events pending; clear them so the next check sees one event.
    wr(l1i_pkg::ADR_EVT_STATUS, 16'h000f);
    wr(l1i_pkg::ADR_EVT_MASK, 16'h0002);
    wr(l1i_pkg::ADR_MASK_ONE, 16'h0080);
    want_one <= 16'h0080;
    lines(5'h17, 1'b1);
    rd(l1i_pkg::ADR_EVT_STATUS, 16'h0002, "event status");
    wr(l1i_pkg::ADR_EVT_MASK, 16'h0000);
    lines(5'h17, 1'b0);
    wr(l1i_pkg::ADR_EVT_STATUS, 16'h0002);
    rd(l1i_pkg::ADR_EVT_STATUS, 16'h0, "event status");
    wr(l1i_pkg::ADR_MASK_ONE, 16'hffff);
    @(posedge ref_clk);
    clock_domain_reset <= 1'b1;
    @(posedge ref_clk);
    clock_domain_reset <= 1'b0;
    rd(l1i_pkg::ADR_MASK_ONE, 16'h0, "mask one");
    lines(5'h1f, 1'b0);
    close_out();
  end
endmodule : l1i_level1_irq_test
`default_nettype wire
